// *** design/bpcr_pkg.sv ***
package bpcr_pkg;
  localparam logic [5:0] BPCR_CMD_DWORD = 6'h01;
  localparam logic [15:0] BPCR_CMD_RESET = 16'h0000;
  // Writable bits: 0,1,2,5,6 in byte 0; 8,9 in byte 1
  localparam logic [15:0] BPCR_CMD_WMASK = 16'h0367;
  localparam int BPCR_BIT_IO = 0;
  localparam int BPCR_BIT_MEM = 1;
  localparam int BPCR_BIT_MST = 2;
  localparam int BPCR_BIT_SPC = 3;
  localparam int BPCR_BIT_MWI = 4;
  localparam int BPCR_BIT_VGA = 5;
  localparam int BPCR_BIT_PER = 6;
  localparam int BPCR_BIT_SERR = 8;
  localparam int BPCR_BIT_FB2B = 9;
  localparam logic [9:0] BPCR_PAL_A = 10'h3C6;
  localparam logic [9:0] BPCR_PAL_B = 10'h3C8;
  localparam logic [9:0] BPCR_PAL_C = 10'h3C9;
endpackage

// *** design/bpcr_sync.sv ***
// Two-flop synchroniser, one per bit
module bpcr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_q;
  // First stage feeds only the second stage
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= '0;
      q_out <= '0;
    end else begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end
endmodule

// *** design/bpcr_top.sv ***
// Primary command register with decode gating
module bpcr_top (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [5:0] cfg_dword_in,
  input wire logic [3:0] cfg_be_n_in,
  input wire logic [31:0] cfg_wdata_in,
  input wire logic io_req_in,
  input wire logic io_write_in,
  input wire logic io_in_range_in,
  input wire logic [31:0] io_addr_in,
  input wire logic mem_req_in,
  input wire logic mem_in_range_in,
  input wire logic sec_req_in,
  input wire logic sec_cfg_in,
  input wire logic spc_req_in,
  input wire logic mwi_fwd_in,
  input wire logic perr_det_in,
  input wire logic addr_perr_in,
  output logic [31:0] cfg_rdata_out,
  output logic cfg_ack_out,
  output logic io_claim_out,
  output logic vga_claim_out,
  output logic mem_claim_out,
  output logic sec_claim_out,
  output logic pri_init_en_out,
  output logic cfg_fwd_out,
  output logic spc_claim_out,
  output logic mwi_issue_out,
  output logic perr_drive_out,
  output logic dpr_set_out,
  output logic serr_ape_out,
  output logic [15:0] cmd_out
);
  logic rst_meta_q;
  logic rst_n_q;
  logic [15:0] cmd_q;
  logic [15:0] wr_d;
  logic [15:0] be_data;
  logic pal_hit;
  logic ce_s;

  // Reset released through two flops
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // Clock enable comes from a pin, so it is synchronised first
  bpcr_sync #(.WIDTH(1)) u_ce_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_q),
    .d_in(ce_in),
    .q_out(ce_s)
  );

  // Byte-enable merge, one slice per byte lane of the command word
  for (genvar b = 0; b < 2; b++) begin : g_lane
    assign be_data[b*8 +: 8] = cfg_be_n_in[b] ? cmd_q[b*8 +: 8] :
                               cfg_wdata_in[b*8 +: 8];
  end
  // Read-only bits are forced back so a stray write cannot set them
  assign wr_d = (be_data & bpcr_pkg::BPCR_CMD_WMASK) |
           (bpcr_pkg::BPCR_CMD_RESET & ~bpcr_pkg::BPCR_CMD_WMASK);

  // Command register; software must load it after reset
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cmd_q <= bpcr_pkg::BPCR_CMD_RESET;
    end else if (ce_s) begin
      if (cfg_wr_in && cfg_dword_in == bpcr_pkg::BPCR_CMD_DWORD) begin
        cmd_q <= wr_d;
      end
    end
  end

  // Config read returns zero for everything but the command word
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cfg_rdata_out <= 32'h0000_0000;
      cfg_ack_out <= 1'b0;
    end else if (ce_s) begin
      cfg_ack_out <= cfg_rd_in | cfg_wr_in;
      if (cfg_rd_in && cfg_dword_in == bpcr_pkg::BPCR_CMD_DWORD) begin
        cfg_rdata_out <= {16'h0000, cmd_q};
      end else if (cfg_rd_in) begin
        cfg_rdata_out <= 32'h0000_0000;
      end
    end
  end

  // Palette: I/O write, low ten bits match, upper half zero
  assign pal_hit = io_req_in && io_write_in &&
    (io_addr_in[31:16] == 16'h0000) &&
    (io_addr_in[9:0] == bpcr_pkg::BPCR_PAL_A ||
     io_addr_in[9:0] == bpcr_pkg::BPCR_PAL_B ||
     io_addr_in[9:0] == bpcr_pkg::BPCR_PAL_C);

  // Claim decisions, registered so outputs come from flops
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      io_claim_out <= 1'b0;
      vga_claim_out <= 1'b0;
      mem_claim_out <= 1'b0;
      sec_claim_out <= 1'b0;
      pri_init_en_out <= 1'b0;
      cfg_fwd_out <= 1'b0;
      spc_claim_out <= 1'b0;
      mwi_issue_out <= 1'b0;
    end else if (ce_s) begin
      io_claim_out <= io_req_in && io_in_range_in &&
                      cmd_q[bpcr_pkg::BPCR_BIT_IO];
      // Snoop path bypasses the range; snoop off leaves range only
      vga_claim_out <= pal_hit && cmd_q[bpcr_pkg::BPCR_BIT_VGA];
      mem_claim_out <= mem_req_in && mem_in_range_in &&
                       cmd_q[bpcr_pkg::BPCR_BIT_MEM];
      sec_claim_out <= sec_req_in && cmd_q[bpcr_pkg::BPCR_BIT_MST];
      pri_init_en_out <= cmd_q[bpcr_pkg::BPCR_BIT_MST];
      cfg_fwd_out <= sec_cfg_in;
      spc_claim_out <= spc_req_in && cmd_q[bpcr_pkg::BPCR_BIT_SPC];
      mwi_issue_out <= mwi_fwd_in && cmd_q[bpcr_pkg::BPCR_BIT_MST];
    end
  end

  // Parity reporting gated by the response bit
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      perr_drive_out <= 1'b0;
      dpr_set_out <= 1'b0;
      serr_ape_out <= 1'b0;
      cmd_out <= bpcr_pkg::BPCR_CMD_RESET;
    end else if (ce_s) begin
      perr_drive_out <= perr_det_in && cmd_q[bpcr_pkg::BPCR_BIT_PER];
      dpr_set_out <= perr_det_in && pri_init_en_out &&
                     cmd_q[bpcr_pkg::BPCR_BIT_PER];
      serr_ape_out <= addr_perr_in && cmd_q[bpcr_pkg::BPCR_BIT_PER] &&
                      cmd_q[bpcr_pkg::BPCR_BIT_SERR];
      cmd_out <= cmd_q;
    end
  end

  // Disabled I/O bit never yields a claim one cycle later
  AST_IO_GATE: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    ce_s && !cmd_q[bpcr_pkg::BPCR_BIT_IO] |=> !io_claim_out)
    else $error("io claim while disabled");
  // Enabled I/O bit claims an in-range cycle
  AST_IO_ON: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    ce_s && io_req_in && io_in_range_in &&
    cmd_q[bpcr_pkg::BPCR_BIT_IO] |=> io_claim_out)
    else $error("io claim missing");
  // Enabled memory bit claims an in-range cycle
  AST_MEM_GATE: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    ce_s && mem_req_in && mem_in_range_in &&
    cmd_q[bpcr_pkg::BPCR_BIT_MEM] |=> mem_claim_out)
    else $error("memory claim missing");
  // Disabled memory bit never claims
  AST_MEM_OFF: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    ce_s && !cmd_q[bpcr_pkg::BPCR_BIT_MEM] |=> !mem_claim_out)
    else $error("memory claim while disabled");
  // Master off: no secondary response and no primary initiation
  AST_MST_OFF: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    ce_s && !cmd_q[bpcr_pkg::BPCR_BIT_MST] |=> !sec_claim_out &&
    !pri_init_en_out)
    else $error("master activity while disabled");
  // Master on: secondary cycles are taken for upstream forwarding
  AST_MST_ON: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    ce_s && sec_req_in && cmd_q[bpcr_pkg::BPCR_BIT_MST] |=> sec_claim_out)
    else $error("secondary claim missing");
  // Master on: primary initiation is allowed
  AST_INIT_ON: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    ce_s && cmd_q[bpcr_pkg::BPCR_BIT_MST] |=> pri_init_en_out)
    else $error("primary initiation not enabled");
  // Configuration cycles are always forwarded
  AST_CFG_FWD: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    ce_s && sec_cfg_in |=> cfg_fwd_out)
    else $error("config not forwarded");
  // Forwarding of configuration does not wait for master enable
  AST_CFG_IND: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    ce_s && sec_cfg_in && !cmd_q[bpcr_pkg::BPCR_BIT_MST] |=> cfg_fwd_out)
    else $error("config blocked by master enable");
  // Special-cycle bit stays zero and nothing is claimed
  AST_RO_BITS: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    cmd_q[bpcr_pkg::BPCR_BIT_SPC] == 1'b0 && !spc_claim_out)
    else $error("read-only bit set");
  // A special cycle on the bus is ignored
  AST_SPC_IGNORE: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    ce_s && spc_req_in |=> !spc_claim_out)
    else $error("special cycle claimed");
  // Invalidate enable bit stays zero in the register and its copy
  AST_MWI_RO: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    cmd_q[bpcr_pkg::BPCR_BIT_MWI] == 1'b0 && !cmd_out[bpcr_pkg::BPCR_BIT_MWI])
    else $error("invalidate enable set");
  // Invalidate is issued only on behalf of another master
  AST_MWI_ONLY: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    ce_s && !mwi_fwd_in |=> !mwi_issue_out)
    else $error("invalidate issued on its own");
  // An I/O read is never a palette write
  AST_PAL_READ: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    ce_s && !io_write_in |=> !vga_claim_out)
    else $error("palette claim on a read");
  // Palette decode needs the upper address half at zero
  AST_PAL_HIGH: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    ce_s && io_addr_in[31:16] != 16'h0000 |=> !vga_claim_out)
    else $error("palette claim with upper address set");
  // Snoop on: palette writes claimed whatever the range says
  AST_VGA: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    ce_s && pal_hit && cmd_q[bpcr_pkg::BPCR_BIT_VGA] |=> vga_claim_out)
    else $error("palette write not snooped");
  // Snoop off: no snoop claim at all
  AST_VGA_OFF: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    ce_s && !cmd_q[bpcr_pkg::BPCR_BIT_VGA] |=> !vga_claim_out)
    else $error("palette snooped while disabled");
  // Snoop off: a palette write outside the range is left alone
  AST_VGA_OUT: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    ce_s && pal_hit && !cmd_q[bpcr_pkg::BPCR_BIT_VGA] &&
    !io_in_range_in |=> !io_claim_out && !vga_claim_out)
    else $error("palette claimed outside range");
  // Parity response off silences every report
  AST_PERR: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    ce_s && !cmd_q[bpcr_pkg::BPCR_BIT_PER] |=> !perr_drive_out &&
    !serr_ape_out && !dpr_set_out)
    else $error("parity reported while disabled");
  // Parity response on drives the error output
  AST_PERR_ON: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    ce_s && perr_det_in && cmd_q[bpcr_pkg::BPCR_BIT_PER] |=> perr_drive_out)
    else $error("parity error not driven");
  // Address parity reaches the system error path when allowed
  AST_SERR_ON: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    ce_s && addr_perr_in && cmd_q[bpcr_pkg::BPCR_BIT_PER] &&
    cmd_q[bpcr_pkg::BPCR_BIT_SERR] |=> serr_ape_out)
    else $error("address parity not signalled");
  // Data parity reported only while acting as primary master
  AST_DPR_ON: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    ce_s && perr_det_in && pri_init_en_out &&
    cmd_q[bpcr_pkg::BPCR_BIT_PER] |=> dpr_set_out)
    else $error("data parity not reported");
  // Every accepted access is answered the next cycle
  AST_ACK: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    ce_s && (cfg_rd_in || cfg_wr_in) |=> cfg_ack_out)
    else $error("config access not answered");
  // No answer follows an enabled cycle with no access
  AST_ACK_ONE: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    ce_s && !cfg_rd_in && !cfg_wr_in |=> !cfg_ack_out)
    else $error("config answer without access");
  // Reading the command word returns the register
  AST_RD_CMD: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    ce_s && cfg_rd_in && cfg_dword_in == bpcr_pkg::BPCR_CMD_DWORD |=>
    cfg_rdata_out == {16'h0000, $past(cmd_q)})
    else $error("command read data wrong");
  // Any other word of the space reads as zero
  AST_RD_RSVD: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    ce_s && cfg_rd_in && cfg_dword_in != bpcr_pkg::BPCR_CMD_DWORD |=>
    cfg_rdata_out == 32'h0000_0000)
    else $error("reserved word not zero");
  // Reserved command bits never leave zero
  AST_RSVD_ZERO: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    cmd_out[15:10] == 6'h00 && !cmd_out[7])
    else $error("reserved command bit set");
  // A write with both low lanes disabled changes nothing
  AST_BE_KEEP: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    ce_s && cfg_wr_in && cfg_be_n_in[1:0] == 2'b11 |=>
    $stable(cmd_q))
    else $error("masked write changed register");
  // Low lane enabled: writable bits of byte 0 take the data
  AST_BE_LOW: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    ce_s && cfg_wr_in && cfg_dword_in == bpcr_pkg::BPCR_CMD_DWORD &&
    !cfg_be_n_in[0] |=> cmd_q[7:0] ==
    ($past(cfg_wdata_in[7:0]) & 8'(bpcr_pkg::BPCR_CMD_WMASK)))
    else $error("low command byte not written");
  // Second lane enabled: writable bits of byte 1 take the data
  AST_BE_HIGH: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    ce_s && cfg_wr_in && cfg_dword_in == bpcr_pkg::BPCR_CMD_DWORD &&
    !cfg_be_n_in[1] |=> cmd_q[15:8] ==
    ($past(cfg_wdata_in[15:8]) & 8'(bpcr_pkg::BPCR_CMD_WMASK >> 8)))
    else $error("high command byte not written");
  // Writes to any other word are dropped
  AST_OTHER_DW: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    ce_s && cfg_wr_in && cfg_dword_in != bpcr_pkg::BPCR_CMD_DWORD |=>
    $stable(cmd_q))
    else $error("reserved write changed register");
  // Clock enable low freezes the register and the answer
  AST_FROZEN: assert property (
    @(posedge clk_in) disable iff (!rst_n_q)
    !ce_s |=> $stable(cmd_q) && $stable(cfg_ack_out))
    else $error("state moved while frozen");
endmodule

// *** dv/bpcr_initiator.sv ***
module bpcr_initiator (
  input wire logic clk_in,
  input wire logic en_in,
  output logic [10:0] req_out,
  output logic [31:0] addr_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int k;
  initial req_out = '0;
  initial addr_out = '0;
  // Random cycles; most addresses hit a palette slot in some alias
  always @(posedge clk_in) begin
    #1;
    k = $urandom % 4;
    req_out <= en_in ? 11'($urandom) : '0;
    case (k)
      0: addr_out <= {16'h0000, 6'($urandom), bpcr_pkg::BPCR_PAL_A};
      1: addr_out <= {16'h0000, 6'($urandom), bpcr_pkg::BPCR_PAL_B};
      2: addr_out <= {16'h0000, 6'($urandom), bpcr_pkg::BPCR_PAL_C};
      default: addr_out <= $urandom;
    endcase
  end
endmodule

// *** dv/tb_bpcr_top.sv ***
module tb_bpcr_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in, reset_n_in = 0, ce_in = 1, cfg_wr_in = 0, cfg_rd_in = 0;
  logic io_req_in, io_write_in, io_in_range_in, mem_req_in, mem_in_range_in;
  logic sec_req_in, sec_cfg_in, spc_req_in, mwi_fwd_in, perr_det_in;
  logic addr_perr_in, cfg_ack_out, io_claim_out, vga_claim_out, en = 0;
  logic mem_claim_out, sec_claim_out, pri_init_en_out, cfg_fwd_out;
  logic spc_claim_out, mwi_issue_out, perr_drive_out, dpr_set_out;
  logic serr_ape_out;
  logic [5:0] cfg_dword_in = '0;
  logic [3:0] cfg_be_n_in = '1;
  logic [31:0] cfg_wdata_in = '0, io_addr_in, cfg_rdata_out, r;
  logic [15:0] cmd_out, cmd = '0;
  logic [10:0] rq;
  int n_errors = 0, tests_run = 0;
  assign {addr_perr_in, perr_det_in, mwi_fwd_in, spc_req_in, sec_cfg_in,
    sec_req_in, mem_in_range_in, mem_req_in, io_in_range_in, io_write_in,
    io_req_in} = rq;
  bpcr_top i_bpcr_top (.*);
  bpcr_initiator i_bpcr_initiator (.clk_in, .en_in(en), .req_out(rq),
    .addr_out(io_addr_in));
  initial begin
    clk_in = 0;
    forever #10 clk_in = ~clk_in;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (e !== g) begin
      n_errors++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  // One config access; the model tracks only writable command bits
  task automatic cfg(bit w, logic [5:0] d, logic [3:0] b, logic [31:0] v);
    int i;
    @(posedge clk_in) #1;
    cfg_wr_in = w;
    cfg_rd_in = !w;
    cfg_dword_in = d;
    cfg_be_n_in = b;
    cfg_wdata_in = v;
    @(posedge clk_in) #1;
    cfg_wr_in = 0;
    cfg_rd_in = 0;
    for (i = 0; i < 4 && cfg_ack_out !== 1'b1; i++) @(posedge clk_in) #1;
    if (i == 4) begin
      n_errors++;
      stop_test();
    end
    r = cfg_rdata_out;
    if (w && d == 1 && !b[0]) cmd[7:0] = v[7:0] & 8'h67;
    if (w && d == 1 && !b[1]) cmd[15:8] = v[15:8] & 8'h03;
    if (!w) chk("rdata", d == 1 ? {16'h0000, cmd} : 0, r);
  endtask
  // Traffic phase; claims are compared one cycle after their inputs
  task automatic traffic(int n);
    logic [10:0] e, g;
    bit v, pm;
    v = 0;
    en = 1;
    repeat (n) begin
      @(posedge clk_in) #2;
      g = {io_claim_out, vga_claim_out, mem_claim_out, sec_claim_out,
        pri_init_en_out, cfg_fwd_out, spc_claim_out, perr_drive_out,
        dpr_set_out, serr_ape_out, mwi_issue_out};
      if (v) begin
        chk("claims", e[10:5], g[10:5]);
        chk("reports", e[4:0], g[4:0]);
      end
      pm = io_req_in && io_write_in && io_addr_in[31:16] == 0 &&
        io_addr_in[9:0] inside {10'h3C6, 10'h3C8, 10'h3C9};
      e = {cmd[0] & io_req_in & io_in_range_in, cmd[5] & pm,
        cmd[1] & mem_req_in & mem_in_range_in, cmd[2] & sec_req_in, cmd[2],
        sec_cfg_in, 1'b0, cmd[6] & perr_det_in,
        cmd[6] & cmd[2] & perr_det_in, cmd[6] & cmd[8] & addr_perr_in,
        cmd[2] & mwi_fwd_in};
      v = 1;
    end
    en = 0;
    chk("cmd", cmd, cmd_out);
  endtask
  // Clock enable low: a write is neither answered nor applied
  task automatic frozen();
    ce_in = 0;
    repeat (3) @(posedge clk_in);
    #1 cfg_wr_in = 1;
    cfg_dword_in = 6'h01;
    cfg_be_n_in = 4'h0;
    cfg_wdata_in = ~{16'h0000, cmd};
    @(posedge clk_in) #1;
    cfg_wr_in = 0;
    @(posedge clk_in) #1;
    chk("ack", 0, cfg_ack_out);
    chk("cmd", cmd, cmd_out);
    ce_in = 1;
    repeat (3) @(posedge clk_in);
  endtask
  initial begin
    void'($urandom(97));
    repeat (6) @(posedge clk_in);
    #1 reset_n_in = 1;
    repeat (4) @(posedge clk_in);
    cfg(0, 6'h01, 4'h0, 0);
    traffic(20);
    for (int t = 0; t < 16; t++) begin
      cfg(1, t < 4 ? 6'h01 : 6'($urandom), 4'($urandom), $urandom);
      cfg(0, 6'h01, 4'($urandom), 0);
      cfg(0, 6'($urandom), 4'h0, 0);
      traffic(15);
      $display("test %0d done", t);
    end
    cfg(1, 6'h01, 4'h0, 32'hFFFF_FFFF);
    traffic(40);
    frozen();
    cfg(0, 6'h01, 4'h0, 0);
    $display("test final done");
    stop_test();
  end
endmodule
